// [core/atm_tc_phy.v]
`timescale 1ns/10ps
`include "atm_tc_regs.vh"

module atm_tc_phy (
    input wire sys_clk,
    input wire resetn,
    input wire ce,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    input wire tx_clk,
    input wire [7:0] tx_data,
    input wire tx_parity,
    input wire tx_soc,
    input wire tx_enb_n,
    output reg tx_clav,
    input wire rx_clk,
    output reg [7:0] rx_data,
    output reg rx_parity,
    output reg rx_soc,
    input wire rx_enb_n,
    output reg rx_clav,
    output reg line_tx,
    input wire line_rx,
    input wire timing_ref_in,
    output reg rx_marker_out,
    output wire line_bad
);
    // Symbol table: sixteen nibbles plus escape
    function [4:0] enc5;
        input [3:0] n;
        begin
            case (n)
                4'h0: enc5 = 5'h15;
                4'h1: enc5 = 5'h09;
                4'h2: enc5 = 5'h0a;
                4'h3: enc5 = 5'h0b;
                4'h4: enc5 = 5'h07;
                4'h5: enc5 = 5'h0d;
                4'h6: enc5 = 5'h0e;
                4'h7: enc5 = 5'h0f;
                4'h8: enc5 = 5'h12;
                4'h9: enc5 = 5'h19;
                4'ha: enc5 = 5'h1a;
                4'hb: enc5 = 5'h1b;
                4'hc: enc5 = 5'h17;
                4'hd: enc5 = 5'h1d;
                4'he: enc5 = 5'h1e;
                default: enc5 = 5'h1f;
            endcase
        end
    endfunction

    // Returns {valid, escape, nibble}
    function [5:0] dec5;
        input [4:0] s;
        integer i;
        begin
            dec5 = (s == `SYM_ESC) ? 6'h30 : 6'h00;
            for (i = 0; i < 16; i = i + 1) begin
                if (enc5(i[3:0]) == s) begin
                    dec5 = {2'b10, i[3:0]};
                end
            end
        end
    endfunction

    // Scrambler generator advanced by one nibble
    function [9:0] prng4;
        input [9:0] s;
        integer i;
        begin
            prng4 = s;
            for (i = 0; i < 4; i = i + 1) begin
                prng4 = {prng4[8:0], prng4[9] ^ prng4[6]};
            end
        end
    endfunction

    function [7:0] crc8;
        input [7:0] c;
        input [7:0] d;
        integer i;
        begin
            crc8 = c;
            for (i = 7; i >= 0; i = i - 1) begin
                crc8 = {crc8[6:0], 1'b0} ^
                    ((crc8[7] ^ d[i]) ? `HEC_POLY : 8'h00);
            end
        end
    endfunction

    localparam SLOT_IDLE = 2'b00;
    localparam SLOT_CMD = 2'b01;
    localparam SLOT_DATA = 2'b10;

    // Pin synchronisers; stage 3 holds the sample before an edge
    wire [15:0] async_in;
    reg [15:0] s1;
    reg [15:0] s2;
    reg [15:0] s3;
    assign async_in = {timing_ref_in, line_rx, rx_enb_n, rx_clk,
                       tx_enb_n, tx_soc, tx_parity, tx_data, tx_clk};

    always @(posedge sys_clk) begin
        if (!resetn) begin
            s1 <= 16'hffff;
            s2 <= 16'hffff;
            s3 <= 16'hffff;
        end else if (ce) begin
            s1 <= async_in;
            s2 <= s1;
            s3 <= s2;
        end
    end

    wire tx_edge = s2[0] & ~s3[0];
    wire rx_edge = s2[12] & ~s3[12];
    wire ref_fall = s3[15] & ~s2[15];

    reg [7:0] master_ctrl;
    reg [7:0] hec_ctrl;
    reg par_err;
    reg line_good;
    wire byte_mode = master_ctrl[`BYTE_MODE_BIT];
    wire loopback = master_ctrl[`LOOPBACK_BIT];
    wire status_rd = reg_rd && (reg_addr == `STATUS_ADDR);

    // Transmit cell interface
    wire tx_take = tx_edge & ~s3[11];
    wire tx_par_bad = ~^{s3[9], s3[8:1]};
    wire [8:0] tx_count;
    wire [8:0] tx_head;
    reg tx_pop;
    reg [5:0] tx_in_cnt;
    wire [8:0] tx_free = `FIFO_BYTES - tx_count;
    wire tx_mid = (tx_in_cnt != 6'h00) && (tx_in_cnt < `NEAR_END_BYTE);

    cell_fifo u_tx_fifo (
        .clk(sys_clk),
        .resetn(resetn),
        .ce(ce),
        .push(tx_take),
        .push_data({s3[10], s3[8:1]}),
        .pop(tx_pop),
        .pop_data(tx_head),
        .count(tx_count)
    );

    always @(posedge sys_clk) begin
        if (!resetn) begin
            tx_clav <= 1'b0;
            tx_in_cnt <= 6'h00;
        end else if (ce && tx_edge) begin
            if (tx_take) begin
                tx_in_cnt <= s3[10] ? 6'h01 : tx_in_cnt + 6'h01;
            end
            if (byte_mode) begin
                tx_clav <= tx_free > `BYTE_SPACE;
            end else begin
                tx_clav <= tx_mid || (tx_free > `CELL_SPACE);
            end
        end
    end

    // Transmit framer and line coder
    reg [4:0] sym_sh;
    reg [2:0] bit_cnt;
    reg phase;
    reg [1:0] slot;
    reg [3:0] cmd_lo;
    reg [7:0] cur_byte;
    reg in_cell;
    reg [5:0] byte_idx;
    reg [7:0] hec_acc;
    reg [9:0] tx_prng;
    reg [9:0] tx_age;
    reg first_cell;
    reg mark_pend;
    reg rx_mark_evt;
    reg [4:0] next_sym;
    reg [7:0] out_byte;
    wire sym_load = (bit_cnt == `SYM_LAST_BIT);
    wire need_reset = first_cell || (tx_age == `PRNG_PERIOD);
    wire [7:0] hec_val = hec_acc ^ `HEC_COSET ^
        (hec_ctrl[`HEC_BAD_BIT] ? `HEC_BAD_MASK : 8'h00);

    always @* begin
        out_byte = tx_head[7:0];
        if (byte_idx == `HEC_BYTE_IDX && hec_ctrl[`HEC_INSERT_BIT]) begin
            out_byte = hec_val;
        end
        tx_pop = 1'b0;
        if (phase == 1'b0) begin
            if (mark_pend || !in_cell) begin
                next_sym = (mark_pend || tx_count >= `CELL_SPACE) ?
                    `SYM_ESC : enc5(tx_prng[9:6]);
            end else begin
                next_sym = enc5(out_byte[7:4] ^ tx_prng[9:6]);
                tx_pop = ce && sym_load;
            end
        end else if (slot == SLOT_CMD) begin
            next_sym = (cmd_lo == 4'hf) ? `SYM_ESC : enc5(cmd_lo);
        end else if (slot == SLOT_DATA) begin
            next_sym = enc5(cur_byte[3:0] ^ tx_prng[9:6]);
        end else begin
            next_sym = enc5(tx_prng[9:6]);
        end
    end

    always @(posedge sys_clk) begin
        if (!resetn) begin
            sym_sh <= 5'h00;
            bit_cnt <= 3'h0;
            line_tx <= 1'b0;
            phase <= 1'b0;
            slot <= SLOT_IDLE;
            cmd_lo <= 4'h0;
            cur_byte <= 8'h00;
            in_cell <= 1'b0;
            byte_idx <= 6'h00;
            hec_acc <= 8'h00;
            tx_prng <= `PRNG_SEED;
            tx_age <= 10'h000;
            first_cell <= 1'b1;
            mark_pend <= 1'b0;
        end else if (ce) begin
            line_tx <= line_tx ^ sym_sh[4];
            sym_sh <= {sym_sh[3:0], 1'b0};
            bit_cnt <= sym_load ? 3'h0 : bit_cnt + 3'h1;
            mark_pend <= ref_fall || (loopback && rx_mark_evt) ||
                (mark_pend && !(sym_load && !phase));
            if (sym_load) begin
                sym_sh <= next_sym;
                phase <= ~phase;
                tx_prng <= prng4(tx_prng);
                if (tx_age != `PRNG_PERIOD) begin
                    tx_age <= tx_age + 10'h001;
                end
                if (!phase) begin
                    if (mark_pend) begin
                        slot <= SLOT_CMD;
                        cmd_lo <= `CMD_MARKER;
                    end else if (in_cell) begin
                        slot <= SLOT_DATA;
                        cur_byte <= out_byte;
                        hec_acc <= crc8((byte_idx == 6'h00) ?
                            8'h00 : hec_acc, tx_head[7:0]);
                        byte_idx <= byte_idx + 6'h01;
                        if (byte_idx == `LAST_CELL_BYTE) begin
                            in_cell <= 1'b0;
                        end
                    end else if (tx_count >= `CELL_SPACE) begin
                        slot <= SLOT_CMD;
                        cmd_lo <= need_reset ? 4'hf : `CMD_NO_RESET;
                        in_cell <= 1'b1;
                        byte_idx <= 6'h00;
                    end else begin
                        slot <= SLOT_IDLE;
                    end
                end else if (slot == SLOT_CMD && cmd_lo == 4'hf) begin
                    tx_prng <= `PRNG_SEED;
                    tx_age <= 10'h000;
                    first_cell <= 1'b0;
                end
            end
        end
    end

    // Receive: NRZI decode and symbol framing
    reg [3:0] rx_sh;
    reg [2:0] rx_cnt;
    reg sym_stb;
    reg [5:0] sym_dec;
    wire rx_bit = s2[14] ^ s3[14];
    wire [4:0] rx_word = {rx_sh, rx_bit};
    wire [5:0] rx_look = dec5(rx_word);

    always @(posedge sys_clk) begin
        if (!resetn) begin
            rx_sh <= 4'h0;
            rx_cnt <= 3'h0;
            sym_stb <= 1'b0;
            sym_dec <= 6'h00;
        end else if (ce) begin
            rx_sh <= rx_word[3:0];
            sym_stb <= 1'b0;
            if (rx_word == `SYM_ESC || rx_cnt == `SYM_LAST_BIT) begin
                sym_stb <= 1'b1;
                sym_dec <= rx_look;
                rx_cnt <= rx_look[5] ? 3'h0 : `SYM_SLIP;
            end else begin
                rx_cnt <= rx_cnt + 3'h1;
            end
        end
    end

    // Command interpreter and descrambler
    reg esc_seen;
    reg rx_in_cell;
    reg rx_keep;
    reg rx_half;
    reg [3:0] rx_hi;
    reg [5:0] rx_idx;
    reg [9:0] rx_prng;
    reg [3:0] mark_cnt;
    wire [8:0] rx_count;
    wire [8:0] rx_head;
    reg rx_pop;
    wire sym_esc = sym_dec[4];
    wire [3:0] plain = sym_dec[3:0] ^ rx_prng[9:6];
    wire rx_push = ce && sym_stb && rx_in_cell && rx_keep &&
        !esc_seen && !sym_esc && rx_half;

    cell_fifo u_rx_fifo (
        .clk(sys_clk),
        .resetn(resetn),
        .ce(ce),
        .push(rx_push),
        .push_data({rx_idx == 6'h00, rx_hi, plain}),
        .pop(rx_pop),
        .pop_data(rx_head),
        .count(rx_count)
    );

    always @(posedge sys_clk) begin
        if (!resetn) begin
            esc_seen <= 1'b0;
            rx_in_cell <= 1'b0;
            rx_keep <= 1'b0;
            rx_half <= 1'b0;
            rx_hi <= 4'h0;
            rx_idx <= 6'h00;
            rx_prng <= `PRNG_SEED;
            rx_mark_evt <= 1'b0;
            mark_cnt <= 4'h0;
            rx_marker_out <= 1'b1;
        end else if (ce) begin
            rx_mark_evt <= 1'b0;
            if (mark_cnt != 4'h0) begin
                mark_cnt <= mark_cnt - 4'h1;
            end
            // Low for exactly the reload count of cycles
            rx_marker_out <= (mark_cnt == 4'h0);
            if (sym_stb) begin
                rx_prng <= prng4(rx_prng);
                esc_seen <= sym_esc && !esc_seen;
                if (esc_seen) begin
                    if (sym_esc || sym_dec[3:0] == `CMD_NO_RESET) begin
                        rx_in_cell <= 1'b1;
                        rx_keep <= (`FIFO_BYTES - rx_count) >= `CELL_SPACE;
                        rx_idx <= 6'h00;
                        rx_half <= 1'b0;
                        if (sym_esc) begin
                            rx_prng <= `PRNG_SEED;
                        end
                    end else if (sym_dec[3:0] == `CMD_MARKER) begin
                        rx_mark_evt <= 1'b1;
                        mark_cnt <= `MARK_PULSE;
                    end
                end else if (rx_in_cell && !sym_esc) begin
                    rx_half <= ~rx_half;
                    rx_hi <= plain;
                    if (rx_half) begin
                        rx_idx <= rx_idx + 6'h01;
                        if (rx_idx == `LAST_CELL_BYTE) begin
                            rx_in_cell <= 1'b0;
                        end
                    end
                end
            end
        end
    end

    // Line quality monitor
    reg [9:0] qwin;
    reg [2:0] qcnt;
    reg q_bad;
    reg [2:0] next_qcnt;
    wire sym_bad = sym_stb && !sym_dec[5];
    wire qwrap = (qwin == `QWIN_LAST);

    always @* begin
        next_qcnt = qcnt;
        if (q_bad || sym_bad) begin
            if (qcnt != `QCNT_MAX) begin
                next_qcnt = qcnt + 3'h1;
            end
        end else if (qcnt != `QCNT_MIN) begin
            next_qcnt = qcnt - 3'h1;
        end
    end

    always @(posedge sys_clk) begin
        if (!resetn) begin
            qwin <= 10'h000;
            qcnt <= `QCNT_MAX;
            q_bad <= 1'b0;
            line_good <= 1'b0;
        end else if (ce) begin
            qwin <= qwin + 10'h001;
            q_bad <= !qwrap && (q_bad || sym_bad);
            if (qwrap) begin
                qcnt <= next_qcnt;
                if (next_qcnt == `QCNT_MIN) begin
                    line_good <= 1'b1;
                end else if (next_qcnt == `QCNT_MAX) begin
                    line_good <= 1'b0;
                end
            end
        end
    end

    assign line_bad = ~line_good;

    // Receive cell interface
    reg [5:0] rx_out_cnt;
    wire rx_give = rx_edge && !s3[13] && rx_clav &&
        (rx_count != 9'h000);
    wire [8:0] rx_left = rx_count - {8'h00, rx_give};
    wire [5:0] rx_next_cnt = !rx_give ? rx_out_cnt :
        (rx_head[8] ? 6'h01 : rx_out_cnt + 6'h01);

    always @* begin
        rx_pop = ce && rx_give;
    end

    always @(posedge sys_clk) begin
        if (!resetn) begin
            rx_clav <= 1'b0;
            rx_soc <= 1'b0;
            rx_data <= 8'h00;
            rx_parity <= 1'b1;
            rx_out_cnt <= 6'h00;
        end else if (ce && rx_edge) begin
            rx_soc <= rx_give && rx_head[8];
            rx_out_cnt <= rx_next_cnt;
            if (rx_give) begin
                rx_data <= rx_head[7:0];
                rx_parity <= ~^rx_head[7:0];
            end
            if (byte_mode) begin
                rx_clav <= rx_left != 9'h000;
            end else begin
                rx_clav <= (rx_next_cnt != 6'h00 &&
                    rx_next_cnt < `CELL_BYTES) ||
                    rx_left >= `CELL_SPACE;
            end
        end
    end

    // Register port
    always @(posedge sys_clk) begin
        if (!resetn) begin
            master_ctrl <= `MASTER_CTRL_RESET;
            hec_ctrl <= `HEC_CTRL_RESET;
            par_err <= 1'b0;
            reg_rdata <= 8'h00;
        end else if (ce) begin
            par_err <= (tx_take && tx_par_bad) ||
                (par_err && !status_rd);
            if (reg_wr && reg_addr == `MASTER_CTRL_ADDR) begin
                master_ctrl <= reg_wdata;
            end
            if (reg_wr && reg_addr == `HEC_CTRL_ADDR) begin
                hec_ctrl <= reg_wdata;
            end
            if (reg_rd) begin
                case (reg_addr)
                    `MASTER_CTRL_ADDR: reg_rdata <= master_ctrl;
                    `HEC_CTRL_ADDR: reg_rdata <= hec_ctrl;
                    `STATUS_ADDR: begin
                        reg_rdata <= 8'h00;
                        reg_rdata[`GOOD_SIG_BIT] <= line_good;
                        reg_rdata[`PARITY_ERR_BIT] <= par_err;
                    end
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end
endmodule

// [core/atm_tc_regs.vh]
`ifndef ATM_TC_REGS_VH
`define ATM_TC_REGS_VH

// Register offsets
`define MASTER_CTRL_ADDR 8'h00
`define STATUS_ADDR 8'h01
`define HEC_CTRL_ADDR 8'h03

// Register reset values
`define MASTER_CTRL_RESET 8'h00
`define HEC_CTRL_RESET 8'h20

// Field positions
`define BYTE_MODE_BIT 1
`define LOOPBACK_BIT 2
`define HEC_BAD_BIT 4
`define HEC_INSERT_BIT 5
`define GOOD_SIG_BIT 6
`define PARITY_ERR_BIT 0

// Cell and buffer sizes
`define CELL_BYTES 6'h35
`define LAST_CELL_BYTE 6'h34
`define NEAR_END_BYTE 6'h33
`define HEC_BYTE_IDX 6'h04
`define FIFO_AW 8
`define FIFO_BYTES 9'h09f
`define CELL_SPACE 9'h035
`define BYTE_SPACE 9'h003

// Line code
`define SYM_ESC 5'h02
`define CMD_NO_RESET 4'h4
`define CMD_MARKER 4'h8
`define PRNG_SEED 10'h3ff
`define PRNG_PERIOD 10'h3ff

// Header check
`define HEC_POLY 8'h07
`define HEC_COSET 8'h55
`define HEC_BAD_MASK 8'h01

// Line quality monitor
`define QWIN_LAST 10'h3ff
`define QCNT_MAX 3'h7
`define QCNT_MIN 3'h0

// Receive marker pulse length in cycles
`define MARK_PULSE 4'h8

// Symbol framing
`define SYM_LAST_BIT 3'h4
`define SYM_SLIP 3'h7

`endif

// [core/cell_fifo.v]
`timescale 1ns/10ps
`include "atm_tc_regs.vh"

module cell_fifo (
    input wire clk,
    input wire resetn,
    input wire ce,
    input wire push,
    input wire [8:0] push_data,
    input wire pop,
    output wire [8:0] pop_data,
    output reg [8:0] count
);
    reg [8:0] mem [0:(1 << `FIFO_AW) - 1];
    reg [`FIFO_AW-1:0] wr_ptr;
    reg [`FIFO_AW-1:0] rd_ptr;
    wire do_push;
    wire do_pop;

    assign do_push = push && (count != `FIFO_BYTES);
    assign do_pop = pop && (count != 9'h000);
    assign pop_data = mem[rd_ptr];

    always @(posedge clk) begin
        if (ce && do_push) begin
            mem[wr_ptr] <= push_data;
        end
    end

    always @(posedge clk) begin
        if (!resetn) begin
            wr_ptr <= {`FIFO_AW{1'b0}};
            rd_ptr <= {`FIFO_AW{1'b0}};
            count <= 9'h000;
        end else if (ce) begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (do_push && !do_pop) begin
                count <= count + 9'h001;
            end else if (do_pop && !do_push) begin
                count <= count - 9'h001;
            end
        end
    end
endmodule

// [tb/atm_layer_model.sv]
`timescale 1ns/10ps
module atm_layer_model (
    output logic tx_clk,
    output logic [7:0] tx_data,
    output logic tx_parity,
    output logic tx_soc,
    output logic tx_enb_n,
    input wire tx_clav,
    output logic rx_clk,
    input wire [7:0] rx_data,
    input wire rx_parity,
    input wire rx_soc,
    output logic rx_enb_n,
    input wire rx_clav
);
    logic [9:0] rx_q [$];
    logic took = 1'b0;
    int rcnt = 0;
    initial begin
        {tx_clk, rx_clk, tx_soc} = 3'b000;
        {tx_parity, tx_enb_n, rx_enb_n} = 3'b111;
        tx_data = 8'h00;
    end
    // Free-running interface clocks of unrelated phase
    initial begin
        #137;
        forever #400 tx_clk = ~tx_clk;
    end
    initial begin
        #391;
        forever #400 rx_clk = ~rx_clk;
    end
    always @(posedge rx_clk) took <= !rx_enb_n && rx_clav;
    always @(negedge rx_clk) begin
        if (took)
            rx_q.push_back({rx_soc, rx_parity, rx_data});
        rcnt <= rcnt + 1;
        rx_enb_n <= (rcnt % 6 == 5);
    end
    // Pauses the enable once in a while in mid-cell
    task automatic send_cell(input logic [7:0] c [53]);
        int i;
        bit held;
        i = 0;
        held = 0;
        @(negedge tx_clk);
        while (tx_clav !== 1'b1)
            @(negedge tx_clk);
        while (i < 53) begin
            if (i % 13 == 7 && !held) begin
                tx_enb_n <= 1'b1;
                held = 1;
            end else begin
                tx_enb_n <= 1'b0;
                tx_data <= c[i];
                tx_parity <= ~^c[i];
                tx_soc <= (i == 0);
                i++;
                held = 0;
            end
            @(negedge tx_clk);
        end
        tx_enb_n <= 1'b1;
        tx_soc <= 1'b0;
        tx_data <= ~c[52];
        tx_parity <= ^c[52];
    endtask
endmodule

// [tb/atm_tc_phy_assertions.sv]
`timescale 1ns/10ps
module atm_tc_phy_checker (
    input wire sys_clk,
    input wire resetn,
    input wire ce,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_rdata,
    input wire [7:0] rx_data,
    input wire rx_parity,
    input wire rx_soc,
    input wire tx_clav,
    input wire rx_clav,
    input wire line_tx,
    input wire rx_marker_out,
    input wire line_bad
);
    localparam int QHOLD = 6144;
    int since_chg;
    int since_rst;
    logic prev_bad;
    default clocking @(posedge sys_clk); endclocking
    always @(posedge sys_clk) begin
        prev_bad <= line_bad;
        if (!resetn) begin
            since_chg <= 0;
            since_rst <= 0;
        end else begin
            since_chg <= (line_bad != prev_bad) ? 0 : since_chg + 1;
            since_rst <= (since_rst < 64) ? since_rst + 1 : since_rst;
        end
    end
    sequence s_low8;
        (!rx_marker_out) [*8] ##1 rx_marker_out;
    endsequence
    sequence s_soc_hold;
        rx_soc [*5] ##[1:5] !rx_soc;
    endsequence
    a_rst_outs: assert property (
        (ce && !resetn) |=> (!tx_clav && !rx_clav && rx_marker_out && line_bad))
        else $error("outputs not in reset state");
    a_status_good: assert property (disable iff (!resetn)
        (ce && reg_rd && reg_addr == 8'h01) |=> reg_rdata[6] == !$past(line_bad))
        else $error("status line-good bit wrong");
    a_unmapped_rd: assert property (disable iff (!resetn)
        (ce && reg_rd && reg_addr == 8'h05) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rx_parity: assert property (disable iff (!resetn)
        rx_parity == ~^rx_data)
        else $error("receive parity not odd");
    a_marker_pulse: assert property (disable iff (!resetn)
        $fell(rx_marker_out) |-> s_low8)
        else $error("marker pulse length wrong");
    a_soc_width: assert property (disable iff (!resetn)
        $rose(rx_soc) |-> s_soc_hold)
        else $error("start of cell width wrong");
    a_quality_hold: assert property (disable iff (!resetn)
        $changed(line_bad) |-> since_chg >= QHOLD)
        else $error("line quality flag changed too soon");
    a_run_limit: assert property (disable iff (!resetn)
        (since_rst > 32) ##0 $stable(line_tx) [*5] |=> $changed(line_tx))
        else $error("line run too long");
endmodule

// [tb/tb_atm_tc_phy.sv]
`timescale 1ns/10ps
module tb_atm_tc_phy;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic brk = 1'b0;
    logic tref = 1'b1;
    wire [7:0] reg_rdata, tx_data, rx_data;
    wire tx_clk, tx_parity, tx_soc, tx_enb_n, tx_clav;
    wire rx_clk, rx_parity, rx_soc, rx_enb_n, rx_clav;
    wire line_tx, rx_marker_out, line_bad;
    wire line_rx = brk ? 1'b0 : line_tx;
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic [7:0] q;
    typedef struct {logic w; logic [7:0] a, d, e;} row_t;
    row_t rows [5] = '{'{1'b0, 8'h00, 8'h00, 8'h00},
        '{1'b0, 8'h03, 8'h00, 8'h20}, '{1'b0, 8'h01, 8'h00, 8'h00},
        '{1'b1, 8'h05, 8'ha5, 8'h00}, '{1'b0, 8'h05, 8'h00, 8'h00}};
    logic [7:0] modes [3] = '{8'h20, 8'h00, 8'h30};
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    atm_tc_phy DUT (.sys_clk(sys_clk), .resetn(resetn), .ce(1'b1),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tx_clk(tx_clk),
        .tx_data(tx_data), .tx_parity(tx_parity), .tx_soc(tx_soc),
        .tx_enb_n(tx_enb_n), .tx_clav(tx_clav), .rx_clk(rx_clk),
        .rx_data(rx_data), .rx_parity(rx_parity), .rx_soc(rx_soc),
        .rx_enb_n(rx_enb_n), .rx_clav(rx_clav), .line_tx(line_tx),
        .line_rx(line_rx), .timing_ref_in(tref),
        .rx_marker_out(rx_marker_out), .line_bad(line_bad));
    atm_layer_model p (.tx_clk(tx_clk), .tx_data(tx_data),
        .tx_parity(tx_parity), .tx_soc(tx_soc), .tx_enb_n(tx_enb_n),
        .tx_clav(tx_clav), .rx_clk(rx_clk), .rx_data(rx_data),
        .rx_parity(rx_parity), .rx_soc(rx_soc), .rx_enb_n(rx_enb_n),
        .rx_clav(rx_clav));
    task chk8(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %0t byte %h expected %h", $time, g, e);
        end
    endtask
    task chk1(input logic g, input logic e);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %0t flag %b expected %b", $time, g, e);
        end
    endtask
    task reg_acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                 output logic [7:0] r);
        @(negedge sys_clk);
        reg_wr = w;
        reg_rd = !w;
        reg_addr = a;
        reg_wdata = d;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        r = reg_rdata;
    endtask
    task automatic wait_for(input bit which, input logic v, input int lim);
        int n;
        n = 0;
        while (((which ? line_bad : rx_marker_out) !== v) && n < lim) begin
            @(negedge sys_clk);
            n++;
        end
    endtask
    task rst_chk;
        @(negedge sys_clk);
        resetn = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk1(tx_clav, 1'b0);
        chk1(rx_clav, 1'b0);
        chk1(rx_marker_out, 1'b1);
        chk1(line_bad, 1'b1);
        chk1(rx_parity, 1'b1);
        chk8(rx_data, 8'h00);
        resetn = 1'b1;
    endtask
    function automatic logic [7:0] hec_of(input logic [31:0] h);
        logic [7:0] r;
        r = 8'h00;
        for (int k = 31; k >= 0; k--)
            r = {r[6:0], 1'b0} ^ ((r[7] ^ h[k]) ? 8'h07 : 8'h00);
        return r ^ 8'h55;
    endfunction
    task automatic cell_test(input logic [7:0] hctl);
        logic [7:0] c [53];
        logic [7:0] h;
        logic [7:0] e;
        int n;
        reg_acc(1'b1, 8'h03, hctl, q);
        for (int i = 0; i < 53; i++)
            c[i] = 8'(i * 29) ^ hctl;
        c[5] = 8'h00;
        h = hec_of({c[0], c[1], c[2], c[3]});
        c[4] = h ^ 8'h5a;
        e = hctl[5] ? (hctl[4] ? h ^ 8'h01 : h) : c[4];
        p.rx_q.delete();
        p.send_cell(c);
        n = 0;
        while (p.rx_q.size() < 53 && n < 3000) begin
            @(negedge sys_clk);
            n++;
        end
        repeat (600) @(negedge sys_clk);
        chk8(8'(p.rx_q.size()), 8'h35);
        for (int i = 0; i < 53 && i < p.rx_q.size(); i++) begin
            h = (i == 4) ? e : c[i];
            chk8(p.rx_q[i][7:0], h);
            chk1(p.rx_q[i][8], ~^h);
            chk1(p.rx_q[i][9], i == 0);
        end
    endtask
    task summarize;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt++;
            $display("[FAIL] %0t run did not finish", $time);
            summarize();
        end
    end
    initial begin
        rst_chk();
        $display("reset test done");
        foreach (rows[i]) begin
            reg_acc(rows[i].w, rows[i].a, rows[i].d, q);
            if (!rows[i].w)
                chk8(q, rows[i].e);
        end
        $display("register test done");
        foreach (modes[i])
            cell_test(modes[i]);
        reg_acc(1'b1, 8'h00, 8'h02, q);
        cell_test(8'h20);
        reg_acc(1'b1, 8'h00, 8'h00, q);
        $display("header check mode tests done");
        // Marker requested while a cell is on the line
        fork
            cell_test(8'h20);
            begin
                repeat (700) @(negedge sys_clk);
                tref = 1'b0;
                wait_for(1'b0, 1'b0, 400);
                chk1(rx_marker_out, 1'b0);
                tref = 1'b1;
            end
        join
        $display("marker test done");
        // Looped marker must come back a second time after the reference is released
        reg_acc(1'b1, 8'h00, 8'h04, q);
        tref = 1'b0;
        wait_for(1'b0, 1'b0, 400);
        tref = 1'b1;
        wait_for(1'b0, 1'b1, 400);
        wait_for(1'b0, 1'b0, 400);
        chk1(rx_marker_out, 1'b0);
        reg_acc(1'b1, 8'h00, 8'h00, q);
        $display("loopback marker test done");
        wait_for(1'b1, 1'b0, 9000);
        chk1(line_bad, 1'b0);
        reg_acc(1'b0, 8'h01, 8'h00, q);
        chk1(q[6], 1'b1);
        chk1(q[0], 1'b0);
        brk = 1'b1;
        wait_for(1'b1, 1'b1, 9000);
        chk1(line_bad, 1'b1);
        brk = 1'b0;
        $display("line quality test done");
        rst_chk();
        reg_acc(1'b0, 8'h01, 8'h00, q);
        chk1(q[6], 1'b0);
        $display("second reset test done");
        summarize();
    end
endmodule
bind atm_tc_phy atm_tc_phy_checker u_chk (.sys_clk(sys_clk),
    .resetn(resetn), .ce(ce), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_rdata(reg_rdata), .rx_data(rx_data), .rx_parity(rx_parity),
    .rx_soc(rx_soc), .tx_clav(tx_clav), .rx_clav(rx_clav),
    .line_tx(line_tx), .rx_marker_out(rx_marker_out), .line_bad(line_bad));
